// *** hw/adcsp_map.svh ***
// Constants of the converter serial port: command layout, checksum, timing.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef ADCSP_MAP_SVH
`define ADCSP_MAP_SVH

// Core clock period and the conversion time, each in nanoseconds
`define ADCSP_CLK_PERIOD_NS 10
`define ADCSP_CONV_TIME_NS  250
// Least time, so the cycle count rounds up
`define ADCSP_CONV_CYCLES   ((`ADCSP_CONV_TIME_NS + `ADCSP_CLK_PERIOD_NS - 1) / `ADCSP_CLK_PERIOD_NS)

// Frame lengths in serial clocks
`define ADCSP_CMD_BITS      6'd16
`define ADCSP_CRC_BITS      6'd24
`define ADCSP_TX_BITS       48

// Command word field positions
`define ADCSP_CMD_WR_BIT    15
`define ADCSP_CMD_ADDR_HI   14
`define ADCSP_CMD_ADDR_LO   12

// Register addresses in the map
`define ADCSP_ADDR_SETUP    3'h1
`define ADCSP_ADDR_FIRST    3'h1
`define ADCSP_ADDR_LAST     3'h5

// Checksum enable bits of the setup register, reset values
`define ADCSP_SETUP_CRC_W   5
`define ADCSP_SETUP_CRC_R   4
`define ADCSP_CRC_W_RESET   1'b0
`define ADCSP_CRC_R_RESET   1'b0

// Polynomial x^8 + x^2 + x + 1 and its low byte
`define ADCSP_CRC_POLY      9'h107
`define ADCSP_CRC_TAPS      8'h07

`endif

// *** hw/adcsp_pkg.sv ***
// Types shared by the converter serial port modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package adcsp_pkg;

  // One 16-bit command as the host sends it
  typedef struct packed {
    logic        wr;    // Set for a write
    logic [2:0]  addr;  // Register address
    logic [11:0] data;  // Write data, ignored on reads
  } adcsp_cmd_t;

  // What the link side caught during one frame
  typedef struct packed {
    logic [23:0] word;    // First 24 input bits, first bit at the top
    logic [5:0]  bits;    // Input bits seen, saturating at 24
    logic        crc_ok;  // Checksum over 24 bits came out clean
  } adcsp_rx_t;

  // Output words for both serial lines, first bit at the top
  typedef struct packed {
    logic [47:0] line_a;
    logic [47:0] line_b;
  } adcsp_tx_t;

  // Conversion sequencer
  typedef enum logic [0:0] {
    ADCSP_IDLE,
    ADCSP_CONV
  } adcsp_state_t;

endpackage

`default_nettype wire

// *** hw/adcsp_crc8.sv ***
// Parallel 8-bit checksum over a W-bit word whose top byte is inverted.
// Assumes W of at least 9; combinational.
`default_nettype none
`include "adcsp_map.svh"

module adcsp_crc8 #(
  parameter int unsigned W = 32  // Width of the protected word
) (
  input  wire logic [W-1:0] data,  // Word to protect
  output logic      [7:0]   crc    // Remainder
);

  // Long division: XOR the polynomial wherever the leading bit is one
  always_comb begin
    logic [W+7:0] rem;
    rem = {~data[W-1:W-8], data[W-9:0], 8'h00};  // see [R14]
    for (int i = W + 7; i >= 8; i--) begin
      if (rem[i]) begin
        rem[i -: 9] = rem[i -: 9] ^ `ADCSP_CRC_POLY;  // see [R13] see [R15]
      end
    end
    crc = rem[7:0];
  end

endmodule

`default_nettype wire

// *** hw/adcsp_link.sv ***
// Serial-clock side of the port: shifts out prepared words, catches input.
// Assumes tx holds steady from just after chip select falls until it rises,
// and rx is read by the core only after the frame ends.
`default_nettype none
`include "adcsp_map.svh"

module adcsp_link (
  input  wire logic              sclk,       // Serial clock from the host
  input  wire logic              cs_n,       // Chip select, frames everything
  input  wire logic              rst,        // Core reset, only clears rx state
  input  wire logic              sdi,        // Serial input
  input  wire adcsp_pkg::adcsp_tx_t tx,      // Words to shift out
  output logic                   sdo_a,      // First output line data
  output logic                   sdo_b,      // Second output line data
  output logic                   sdo_oe_n,   // Low while lines are driven
  output adcsp_pkg::adcsp_rx_t   rx,         // Caught frame
  output logic                   frame_tgl   // Flips on every clocked frame
);

  logic [5:0] idx;        // Output bit index
  logic [5:0] next_idx;
  logic       fresh;      // No falling edge yet in this frame
  logic [7:0] lfsr;       // Running remainder of the input bits
  adcsp_pkg::adcsp_rx_t next_rx;
  logic [7:0] next_lfsr;
  logic       next_tgl;

  // Index moves on rising edges; chip select high parks it on the top bit
  always_comb begin
    next_idx = (idx == 6'(`ADCSP_TX_BITS - 1)) ? idx : idx + 6'd1;
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      idx <= 6'd0;
    end else begin
      idx <= next_idx;  // see [R17]
    end
  end

  // First bit shows as soon as chip select falls, no edge needed
  assign sdo_a    = tx.line_a[6'(`ADCSP_TX_BITS - 1) - idx];  // see [R17]
  assign sdo_b    = tx.line_b[6'(`ADCSP_TX_BITS - 1) - idx];
  assign sdo_oe_n = cs_n;

  // Marks the first falling edge; drops last frame's count
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // Input capture and serial checksum, one bit per falling edge
  always_comb begin
    logic [5:0] base;
    logic       fb;
    fb        = 1'b0;
    base      = fresh ? 6'd0 : rx.bits;
    next_rx   = rx;
    next_lfsr = fresh ? 8'h00 : lfsr;
    next_tgl  = fresh ? ~frame_tgl : frame_tgl;
    if (fresh) begin
      next_rx.crc_ok = 1'b0;
    end
    if (base < `ADCSP_CRC_BITS) begin
      next_rx.word[5'(23 - base)] = sdi;
      // Top byte inverted as it enters the divider
      fb        = next_lfsr[7] ^ (sdi ^ (base < 6'd8));
      next_lfsr = {next_lfsr[6:0], 1'b0} ^ ({8{fb}} & `ADCSP_CRC_TAPS);  // see [R21]
      next_rx.bits = base + 6'd1;
      if (base == `ADCSP_CRC_BITS - 6'd1) begin
        next_rx.crc_ok = (next_lfsr == 8'h00);  // see [R20] see [R21]
      end
    end
  end

  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      rx        <= '0;
      lfsr      <= 8'h00;
      frame_tgl <= 1'b0;
    end else begin
      rx        <= next_rx;
      lfsr      <= next_lfsr;
      frame_tgl <= next_tgl;
    end
  end

endmodule

`default_nettype wire

// *** hw/adcsp_top.sv ***
// Serial port of a dual simultaneous-sampling converter, core clock side.
// Assumes results on conv_a/conv_b in the core domain, and a map
// that answers reg_rd_addr on reg_rd_data at once.
//
// Behaviour
// [R1] Result comes out in the following frame
// [R2] Second pulse after conversion reads that result
// [R3] Read command then one more frame returns data
// [R4] Read: top bit clear, address, rest ignored
// [R5] Write: top bit set, address, twelve data bits
// [R6] Write frame 16 bits, 24 with write checksum
// [R7] Separate enables for read and write checksums
// [R8] Read checksum byte follows results and register data
// [R9] Conversion checksum covers both, first line only
// [R10] Checksum works in both line modes and boost
// [R11] Host must protect the write enabling checksums
// [R12] Protected mode drops writes with bad checksum
// [R13] Polynomial x^8 + x^2 + x + 1
// [R14] Dividend: invert top byte, append eight zeros
// [R15] Remainder of modulo-2 division, eight bits
// [R16] Chip select fall starts conversion, opens frame
// [R17] Shift out first bit first, change on rise
// [R18] Register data presented in the next frame
// [R19] Unmapped read is no-op, results follow
// [R20] Write checksum follows command in same frame
// [R21] Checking runs on serial clock within frame
`default_nettype none
`include "adcsp_map.svh"

module adcsp_top (
  input  wire logic        core_clk,                   // 100 MHz core clock
  input  wire logic        rst,                        // Synchronous, active high
  input  wire logic        cs_n,                       // Chip select pin
  input  wire logic        sclk,                       // Serial clock pin
  input  wire logic        sdi,                        // Serial input pin
  output logic             first_serial_output,        // First output line
  output logic             first_serial_output_oe_n,   // Low while driven
  output logic             second_serial_output,       // Second output line
  output logic             second_serial_output_oe_n,  // Low while driven
  input  wire logic [17:0] conv_a,                     // Converter A result
  input  wire logic [17:0] conv_b,                     // Converter B result
  input  wire logic        one_wire,                   // Both results on first line
  input  wire logic        res_boost,                  // Two extra result bits
  input  wire logic [11:0] reg_rd_data,                // Data of reg_rd_addr
  output logic             conv_start,                 // Sample both inputs now
  output logic             reg_wr_valid,               // Write strobe to the map
  output logic      [2:0]  reg_wr_addr,                // Write address
  output logic      [11:0] reg_wr_data,                // Write data
  output logic      [2:0]  reg_rd_addr,                // Pending read address
  output logic             crc_write_on,               // Write checksums required
  output logic             crc_read_on,                // Read checksums appended
  output logic             crc_write_fail              // A write was dropped
);

  // Conversion time in core cycles
  localparam logic [15:0] CONV_CYCLES = 16'(`ADCSP_CONV_CYCLES);

  // Chip select synchroniser; only cs_s2 and cs_d feed logic
  logic cs_s1;
  logic cs_s2;
  logic cs_d;
  // Frame toggle synchroniser from the serial side
  logic tgl_s1;
  logic tgl_s2;
  logic tgl_seen;             // Toggle value at the last frame end

  // Conversion sequencer
  adcsp_pkg::adcsp_state_t state;
  adcsp_pkg::adcsp_state_t next_state;
  logic [15:0]             cnt;        // Cycles left in the conversion
  logic [15:0]             next_cnt;
  logic [17:0]             res_a;      // Last finished result, converter A
  logic [17:0]             res_b;      // Last finished result, converter B
  logic [17:0]             next_res_a;
  logic [17:0]             next_res_b;
  logic                    next_conv_start;

  // Command state
  logic        pend_valid;        // A mapped read waits for the next frame
  logic        next_pend_valid;
  logic [2:0]  next_rd_addr;
  logic        next_crc_w;
  logic        next_crc_r;
  logic        next_wr_valid;
  logic [2:0]  next_wr_addr;
  logic [11:0] next_wr_data;
  logic        next_fail;
  logic        next_tgl_seen;

  // Output words and the serial side's view of the frame
  adcsp_pkg::adcsp_tx_t tx;
  adcsp_pkg::adcsp_tx_t next_tx;
  adcsp_pkg::adcsp_rx_t rx;
  logic                 frame_tgl;
  logic                 link_a;
  logic                 link_b;
  logic                 link_oe_n;

  // Frame edges as seen on the core clock
  logic cs_fall;
  logic cs_rise;
  logic frame_done;                // Frame ended and had serial clocks
  adcsp_pkg::adcsp_cmd_t cmd;      // Command bits of the ended frame
  logic                  chk_ok;   // Full 24 bits with clean checksum

  // Checksums for the next frame
  logic [15:0] a16;
  logic [15:0] b16;
  logic [15:0] reg_word;
  logic [7:0]  conv_crc;
  logic [7:0]  reg_crc;
  logic [7:0]  crc_a;

  // Two flip-flops before any logic looks at the pins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cs_s1  <= 1'b1;
      cs_s2  <= 1'b1;
      cs_d   <= 1'b1;
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
    end else begin
      cs_s1  <= cs_n;
      cs_s2  <= cs_s1;
      cs_d   <= cs_s2;
      tgl_s1 <= frame_tgl;
      tgl_s2 <= tgl_s1;
    end
  end

  assign cs_fall = cs_d & ~cs_s2;
  assign cs_rise = ~cs_d & cs_s2;

  // Conversion sequencer: a fall starts both converters at once
  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_res_a      = res_a;
    next_res_b      = res_b;
    next_conv_start = 1'b0;
    case (state)
      adcsp_pkg::ADCSP_IDLE: begin
        // A fall while still converting is lost; host must respect the time
        if (cs_fall) begin
          next_state      = adcsp_pkg::ADCSP_CONV;
          next_cnt        = CONV_CYCLES - 16'd1;
          next_conv_start = 1'b1;  // see [R16]
        end
      end
      adcsp_pkg::ADCSP_CONV: begin
        if (cnt == 16'd0) begin
          // Held until the next conversion ends, so any later
          // frame reads it, pipelined or low-latency alike
          next_state = adcsp_pkg::ADCSP_IDLE;
          next_res_a = conv_a;  // see [R1] see [R2]
          next_res_b = conv_b;
        end else begin
          next_cnt = cnt - 16'd1;
        end
      end
      default: begin
        next_state = adcsp_pkg::ADCSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state      <= adcsp_pkg::ADCSP_IDLE;
      cnt        <= 16'd0;
      res_a      <= 18'h00000;
      res_b      <= 18'h00000;
      conv_start <= 1'b0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      res_a      <= next_res_a;
      res_b      <= next_res_b;
      conv_start <= next_conv_start;
    end
  end

  // Serial side is quiet while chip select is high: rx is steady
  assign frame_done = cs_rise & (tgl_s2 != tgl_seen);
  assign cmd        = rx.word[23:8];
  assign chk_ok     = (rx.bits == `ADCSP_CRC_BITS) & rx.crc_ok;

  // Command decode at the end of each frame
  always_comb begin
    next_tgl_seen   = cs_rise ? tgl_s2 : tgl_seen;
    next_pend_valid = pend_valid;
    next_rd_addr    = reg_rd_addr;
    next_crc_w      = crc_write_on;
    next_crc_r      = crc_read_on;
    next_wr_valid   = 1'b0;
    next_wr_addr    = reg_wr_addr;
    next_wr_data    = reg_wr_data;
    next_fail       = 1'b0;
    if (frame_done) begin
      // The frame that just ended served any pending read
      next_pend_valid = 1'b0;  // see [R3]
      if (rx.bits >= `ADCSP_CMD_BITS) begin
        if (!cmd.wr) begin
          // Low twelve bits of a read are not looked at
          if (cmd.addr >= `ADCSP_ADDR_FIRST && cmd.addr <= `ADCSP_ADDR_LAST) begin
            next_pend_valid = 1'b1;  // see [R4] see [R18]
            next_rd_addr    = cmd.addr;
          end
          // Any other address is a no-op; results stay queued  see [R19]
        end else if (crc_write_on && !chk_ok) begin
          // Even a write that would switch protection off is dropped
          next_fail = 1'b1;  // see [R12] see [R6]
        end else begin
          next_wr_valid = 1'b1;  // see [R5]
          next_wr_addr  = cmd.addr;
          next_wr_data  = cmd.data;
          if (cmd.addr == `ADCSP_ADDR_SETUP) begin
            next_crc_r = cmd.data[`ADCSP_SETUP_CRC_R];  // see [R7]
            // Turning protection on needs a clean checksum on this frame
            if (!cmd.data[`ADCSP_SETUP_CRC_W] || chk_ok) begin
              next_crc_w = cmd.data[`ADCSP_SETUP_CRC_W];  // see [R11] see [R7]
            end
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tgl_seen       <= 1'b0;
      pend_valid     <= 1'b0;
      reg_rd_addr    <= 3'h0;
      crc_write_on   <= `ADCSP_CRC_W_RESET;
      crc_read_on    <= `ADCSP_CRC_R_RESET;
      reg_wr_valid   <= 1'b0;
      reg_wr_addr    <= 3'h0;
      reg_wr_data    <= 12'h000;
      crc_write_fail <= 1'b0;
    end else begin
      tgl_seen       <= next_tgl_seen;
      pend_valid     <= next_pend_valid;
      reg_rd_addr    <= next_rd_addr;
      crc_write_on   <= next_crc_w;
      crc_read_on    <= next_crc_r;
      reg_wr_valid   <= next_wr_valid;
      reg_wr_addr    <= next_wr_addr;
      reg_wr_data    <= next_wr_data;
      crc_write_fail <= next_fail;
    end
  end

  // Checksum inputs: 16-bit results of both converters, and the
  // register word, address in the top nibble
  assign a16      = res_a[17:2];
  assign b16      = res_b[17:2];
  assign reg_word = {1'b0, reg_rd_addr, reg_rd_data};

  // Conversion checksum spans both converters together
  adcsp_crc8 #(
    .W (32)
  ) u_conv_crc (
    .data ({a16, b16}),  // see [R9] see [R14]
    .crc  (conv_crc)
  );

  // Register readback checksum
  adcsp_crc8 #(
    .W (16)
  ) u_reg_crc (
    .data (reg_word),
    .crc  (reg_crc)
  );

  // Output words for the next frame; a disabled checksum shifts out zeros
  always_comb begin
    crc_a   = crc_read_on ? conv_crc : 8'h00;  // see [R8]
    next_tx = tx;
    // Rebuilt only between frames so the lines never change under the host
    if (cs_s2) begin
      next_tx.line_b = '0;
      if (pend_valid) begin
        next_tx.line_a = {reg_word, (crc_read_on ? reg_crc : 8'h00), 24'h000000};  // see [R8]
      end else begin
        // Checksum always goes on the first line only  see [R9] see [R10]
        case ({one_wire, res_boost})
          2'b00: begin
            next_tx.line_a = {a16, crc_a, 24'h000000};
            next_tx.line_b = {b16, 32'h00000000};
          end
          2'b01: begin
            next_tx.line_a = {res_a, crc_a, 22'h000000};
            next_tx.line_b = {res_b, 30'h00000000};
          end
          2'b10: begin
            next_tx.line_a = {a16, b16, crc_a, 8'h00};
          end
          default: begin
            next_tx.line_a = {res_a, res_b, crc_a, 4'h0};
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx <= '0;
    end else begin
      tx <= next_tx;
    end
  end

  // Serial side; lines follow its index directly, since the first
  // bit must be out at the chip select fall, before any edge
  adcsp_link u_link (
    .sclk      (sclk),
    .cs_n      (cs_n),
    .rst       (rst),
    .sdi       (sdi),
    .tx        (tx),
    .sdo_a     (link_a),
    .sdo_b     (link_b),
    .sdo_oe_n  (link_oe_n),
    .rx        (rx),
    .frame_tgl (frame_tgl)
  );

  assign first_serial_output       = link_a;
  assign second_serial_output      = link_b;
  assign first_serial_output_oe_n  = link_oe_n;
  assign second_serial_output_oe_n = link_oe_n;

endmodule

`default_nettype wire

// *** bench/adcsp_top_sva.sv ***
// Port checker for the converter serial port, bound onto adcsp_top.
// Assumes one core clock, synchronous active-high reset.
`default_nettype none

module adcsp_top_sva (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        cs_n,
  input wire logic        first_serial_output_oe_n,
  input wire logic        second_serial_output_oe_n,
  input wire logic        conv_start,
  input wire logic        reg_wr_valid,
  input wire logic [2:0]  reg_wr_addr,
  input wire logic [11:0] reg_wr_data,
  input wire logic        crc_write_on,
  input wire logic        crc_read_on,
  input wire logic        crc_write_fail
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [4:0] since_start;       // Core cycles since a start, saturating

  // Saturates, so a long idle never looks like a short gap
  always_ff @(posedge core_clk) begin
    if (rst) begin
      since_start <= 5'h1f;
    end else if (conv_start) begin
      since_start <= 5'h00;
    end else if (since_start != 5'h1f) begin
      since_start <= since_start + 5'h01;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_oe_first_line : assert property (first_serial_output_oe_n == cs_n)
    else $error("line A enable wrong");
  a_oe_second_line : assert property (second_serial_output_oe_n == cs_n)
    else $error("line B enable wrong");
  a_start_on_fall : assert property (conv_start |-> !cs_n && $past(cs_n, 4))
    else $error("start without fall");
  a_conv_spacing : assert property (conv_start |-> since_start >= 5'h18)
    else $error("start too soon");
  a_wr_one_cycle : assert property (reg_wr_valid |=> !reg_wr_valid)
    else $error("strobe too long");
  a_wr_after_frame : assert property (reg_wr_valid |-> cs_n && $past(cs_n, 3))
    else $error("strobe in frame");
  a_wr_fields_hold : assert property (!reg_wr_valid |->
                                      $stable(reg_wr_addr) && $stable(reg_wr_data))
    else $error("fields moved");
  a_drop_no_strobe : assert property (crc_write_fail && crc_write_on |-> !reg_wr_valid)
    else $error("drop strobed");
  a_read_crc_cause : assert property ($changed(crc_read_on) |->
                                      reg_wr_valid || $past(reg_wr_valid))
    else $error("read enable moved");

  c_conversion : cover property (conv_start);
  c_prot_write : cover property (reg_wr_valid && crc_write_on);
  c_dropped    : cover property (crc_write_fail);
endmodule

bind adcsp_top adcsp_top_sva i_adcsp_top_sva (
  .core_clk(core_clk), .rst(rst), .cs_n(cs_n),
  .first_serial_output_oe_n(first_serial_output_oe_n),
  .second_serial_output_oe_n(second_serial_output_oe_n),
  .conv_start(conv_start), .reg_wr_valid(reg_wr_valid),
  .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
  .crc_write_on(crc_write_on), .crc_read_on(crc_read_on),
  .crc_write_fail(crc_write_fail)
);
`default_nettype wire

// *** bench/adcsp_host.sv ***
// Host model: chip select, serial clock and input line.
// Assumes the serial clock idles low and runs only inside frames.
`default_nettype none

module adcsp_host (
  output logic      cs_n,   // Chip select
  output logic      sclk,   // Serial clock, 80 ns period
  output logic      sdi,    // Device serial input
  input  wire logic sdo_a,  // First output line
  input  wire logic sdo_b   // Second output line
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end

  // One frame of n clocks; lasts 540 + 80n ns so core phase stays put
  task automatic frame(input logic [23:0] w, input int n,
                       output logic [47:0] a, output logic [47:0] b);
    a = '0;
    b = '0;
    #3 cs_n = 1'b0;  // Whole access in one frame
    sdi = w[23];
    #40;
    for (int i = 0; i < n; i++) begin
      a[47-i] = sdo_a;  // Bit stands until this rise
      b[47-i] = sdo_b;
      sclk = 1'b1;
      #40 sclk = 1'b0;
      // Command, then checksum, first bit first
      #5 sdi = (i < 23) ? w[22-i] : ~sdi;
      #35;
    end
    cs_n = 1'b1;
    // Released line shows the inverse, never a stale bit
    #5 sdi = ~sdi;
    #492;
  endtask
endmodule
`default_nettype wire

// *** bench/adcsp_top_tb.sv ***
// Bench for the converter serial port, with a host model.
// Assumes a stand-in map that answers read addresses.
`default_nettype none

module adcsp_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        core_clk, rst;                // Core clock and reset
  logic        cs_n, sclk, sdi, sdo_a, sdo_b; // Serial pins
  logic [17:0] conv_a, conv_b;               // Converter results
  logic        one_wire, res_boost;          // Output modes
  logic [11:0] reg_rd_data, reg_wr_data;     // Map data
  logic [2:0]  reg_rd_addr, reg_wr_addr;     // Map addresses
  logic        reg_wr_valid, crc_write_fail; // Write outcome
  logic        crc_write_on, crc_read_on;    // Checksum state
  logic [47:0] cap_a, cap_b;                 // Bits caught last frame
  logic [7:0]  n_wr, n_fail;                 // Accepted and dropped writes
  logic [14:0] last_wr;                      // Last address and data
  int          n_errors, n_tests;

  adcsp_top i_adcsp_top (
    .core_clk(core_clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
    .first_serial_output(sdo_a), .first_serial_output_oe_n(),
    .second_serial_output(sdo_b), .second_serial_output_oe_n(),
    .conv_a(conv_a), .conv_b(conv_b), .one_wire(one_wire), .res_boost(res_boost),
    .reg_rd_data(reg_rd_data), .conv_start(), .reg_wr_valid(reg_wr_valid),
    .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .reg_rd_addr(reg_rd_addr),
    .crc_write_on(crc_write_on), .crc_read_on(crc_read_on),
    .crc_write_fail(crc_write_fail)
  );
  adcsp_host i_adcsp_host (
    .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo_a(sdo_a), .sdo_b(sdo_b)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Stand-in map and write counters
  always @(posedge core_clk) begin
    reg_rd_data <= {9'h0a5, reg_rd_addr};
    if (reg_wr_valid === 1'b1) begin
      n_wr    <= n_wr + 8'h01;
      last_wr <= {reg_wr_addr, reg_wr_data};
    end
    if (crc_write_fail === 1'b1) n_fail <= n_fail + 8'h01;
  end

  task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Reference checksum of a w-bit word
  function automatic logic [7:0] crc8(input logic [31:0] d, input int w);
    logic [39:0] v;
    v = {d, 8'h00};
    v[w+7 -: 8] = ~v[w+7 -: 8];
    for (int i = w + 7; i >= 8; i--) begin
      if (v[i]) v[i -: 9] = v[i -: 9] ^ 9'h107;
    end
    return v[7:0];
  endfunction

  task automatic run(input logic [23:0] w, input int n);
    i_adcsp_host.frame(w, n, cap_a, cap_b);
  endtask

  // Write; prot 0 bare, 1 good, 2 bad checksum
  task automatic wr(input logic [2:0] ad, input logic [11:0] d, input int prot);
    logic [15:0] c;
    logic [7:0]  k;
    c = {1'b1, ad, d};
    k = crc8({16'h0, c}, 16) ^ ((prot == 2) ? 8'h01 : 8'h00);
    if (prot == 0) run({c, 8'h00}, 16);
    else run({c, k}, 24);
  endtask

  task automatic set_in(input logic [17:0] a, input logic [17:0] b, input logic o,
                        input logic r);
    @(posedge core_clk);
    conv_a    <= a;
    conv_b    <= b;
    one_wire  <= o;
    res_boost <= r;
    repeat (5) @(posedge core_clk);
  endtask

  task automatic t_latency;
    set_in(18'h2aaaa, 18'h15555, 1'b0, 1'b0);
    run(24'h0, 16);
    set_in(18'h15555, 18'h2aaaa, 1'b0, 1'b0);
    run(24'h0, 16);
    check("a latency", {16'haaaa, 32'h0}, cap_a);
    check("b latency", {16'h5555, 32'h0}, cap_b);
    run(24'h0, 16);
    check("a second", {16'h5555, 32'h0}, cap_a);
    $display("t_latency done");
  endtask

  task automatic t_regs;
    wr(3'h4, 12'h123, 0);
    check("write", {8'h01, 3'h4, 12'h123}, {n_wr, last_wr});
    run({1'b0, 3'h4, 20'hfffff}, 16);
    run(24'h0, 16);
    check("reg read", {4'h4, 9'h0a5, 3'h4, 32'h0}, cap_a);
    run({1'b0, 3'h7, 20'h0}, 16);
    run(24'h0, 16);
    check("unmapped read", {16'h5555, 32'h0}, cap_a);
    $display("t_regs done");
  endtask

  task automatic t_crc_read;
    logic [7:0] k;
    k = crc8(32'haaaa5555, 32);
    wr(3'h1, 12'h010, 0);
    check("crc r only", 2'b01, {crc_write_on, crc_read_on});
    set_in(18'h2aaaa, 18'h15555, 1'b0, 1'b0);
    run(24'h0, 16);
    run(24'h0, 24);
    check("crc 2-line", {16'haaaa, k, 24'h0}, cap_a);
    check("crc b", {16'h5555, 32'h0}, cap_b);
    set_in(18'h2aaaa, 18'h15555, 1'b1, 1'b0);
    run(24'h0, 40);
    check("crc 1-line", {32'haaaa5555, k, 8'h0}, cap_a);
    set_in(18'h2aaaa, 18'h15555, 1'b0, 1'b1);
    run(24'h0, 26);
    check("crc boost", {18'h2aaaa, k, 22'h0}, cap_a);
    check("boost b", {18'h15555, 30'h0}, cap_b);
    set_in(18'h2aaaa, 18'h15555, 1'b0, 1'b0);
    run({1'b0, 3'h4, 20'h0}, 16);
    run(24'h0, 24);
    k = crc8({16'h0, 4'h4, 9'h0a5, 3'h4}, 16);
    check("crc reg", {4'h4, 9'h0a5, 3'h4, k, 24'h0}, cap_a);
    wr(3'h1, 12'h000, 0);
    $display("t_crc_read done");
  endtask

  task automatic t_crc_write;
    logic [7:0] f0;
    wr(3'h1, 12'h020, 0);
    check("bare enable", 1'b0, crc_write_on);
    wr(3'h1, 12'h020, 1);
    check("good enable", 1'b1, crc_write_on);
    f0 = n_fail;
    wr(3'h4, 12'h0f0, 0);
    wr(3'h4, 12'h0f1, 2);
    check("dropped", {8'h02, 8'h05, 3'h1, 12'h020}, {n_fail - f0, n_wr, last_wr});
    wr(3'h4, 12'h0f2, 1);
    check("prot write", {8'h06, 3'h4, 12'h0f2}, {n_wr, last_wr});
    wr(3'h1, 12'h000, 2);
    check("bad clear", {8'h03, 1'b1}, {n_fail - f0, crc_write_on});
    wr(3'h1, 12'h000, 1);
    check("good clear", {8'h07, 1'b0}, {n_wr, crc_write_on});
    $display("t_crc_write done");
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // About 50 us of tests; a hang stops here
  initial begin
    #300000;
    n_errors++;
    end_of_test();
  end

  initial begin
    rst         = 1'b1;
    conv_a      = '0;
    conv_b      = '0;
    one_wire    = 1'b0;
    res_boost   = 1'b0;
    reg_rd_data = '0;
    n_wr        = '0;
    n_fail      = '0;
    last_wr     = '0;
    n_errors    = 0;
    n_tests     = 0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    t_latency();
    t_regs();
    t_crc_read();
    t_crc_write();
    end_of_test();
  end
endmodule
`default_nettype wire
